// ===== ocrb_opamp_control_register_bank.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ocrb_opamp_control_register_bank
  import ocrb_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int NUM_AMPS   = 3
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [ADDR_WIDTH-1:0]     s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]     s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output var  logic [NUM_AMPS-1:0][3:0]  inverting_input_sel,
  output var  logic [NUM_AMPS-1:0][3:0]  noninverting_input_sel,
  output var  logic [NUM_AMPS-1:0][1:0]  slew_power_sel,
  output var  logic [NUM_AMPS-1:0]       amp_output_hiz,
  output var  logic [NUM_AMPS-1:0]       amp_output_to_pins,
  output var  logic [NUM_AMPS-1:0]       amp_output_to_adc_lower,
  output var  logic [NUM_AMPS-1:0]       amp_output_to_adc_upper,
  output var  logic [NUM_AMPS-1:0]       adc_upper_pin_disconnect,
  output var  logic [NUM_AMPS-1:0][2:0]  feedback_tap_sel,
  output var  logic [NUM_AMPS-1:0][7:0]  amp_function_sel,
  output var  logic [NUM_AMPS-1:0]       inverting_pin_expose,
  output var  logic [NUM_AMPS-1:0]       ladder_reverse,
  output var  logic [NUM_AMPS-1:0][5:0]  diff_gain_x3
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic [3:0] reg_slot(input logic [ADDR_WIDTH-1:0] addr);
    logic [9:0] idx;
    idx = 10'(addr >> 2);
    if (idx >= OCRB_AMP0_CONTROL_A_IDX && idx <= OCRB_AMP2_CONTROL_B_IDX) begin
      reg_slot = {1'b1, 3'(idx - OCRB_AMP0_CONTROL_A_IDX)};
    end else begin
      reg_slot = 4'h0;
    end
  endfunction : reg_slot

  // gain of the three-amplifier stage, scaled by three to stay integral
  function automatic logic [5:0] gain_x3(input logic [2:0] tap);
    case (tap)
      3'h0:    gain_x3 = 6'h00;
      3'h1:    gain_x3 = 6'h01;
      3'h2:    gain_x3 = 6'h03;
      3'h3:    gain_x3 = 6'h05;
      3'h4:    gain_x3 = 6'h09;
      3'h5:    gain_x3 = 6'h0D;
      3'h6:    gain_x3 = 6'h15;
      default: gain_x3 = 6'h2D;
    endcase
  endfunction : gain_x3

  // ---------------------------------------------------------------
  // bus state
  // ---------------------------------------------------------------
  logic [7:0]            ctl_reg [OCRB_NUM_REGS];
  logic [7:0]            ctl_next [OCRB_NUM_REGS];
  logic [ADDR_WIDTH-1:0] awaddr_reg;
  logic                  aw_held_reg;
  logic [7:0]            wbyte_reg;
  logic                  wlane_reg;
  logic                  w_held_reg;

  wire       aw_take   = s_axi_awvalid && s_axi_awready;
  wire       w_take    = s_axi_wvalid && s_axi_wready;
  wire       ar_take   = s_axi_arvalid && s_axi_arready;
  wire       wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [3:0] wr_slot   = reg_slot(awaddr_reg);
  wire [3:0] rd_slot   = reg_slot(s_axi_araddr);
  wire       wr_commit = wr_fire && wr_slot[3] && wlane_reg;
  wire [7:0] rd_byte   = rd_slot[3] ? ctl_reg[rd_slot[2:0]] : 8'h00;

  always_comb begin
    for (int i = 0; i < OCRB_NUM_REGS; i++) begin
      ctl_next[i] = (wr_commit && wr_slot[2:0] == 3'(i)) ? wbyte_reg : ctl_reg[i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wbyte_reg  <= s_axi_wdata[7:0];
        wlane_reg  <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // ready flags are registered so the outputs come straight from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !aw_take && !wr_fire;
      s_axi_wready  <= !w_held_reg && !w_take && !wr_fire;
      s_axi_arready <= !s_axi_rvalid && !ar_take;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= OCRB_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_slot[3] ? OCRB_RESP_OKAY : OCRB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path only looks at the stored bytes; nothing is cleared on read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= OCRB_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_slot[3] ? OCRB_RESP_OKAY : OCRB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < OCRB_NUM_REGS; i++) begin
      if (!aresetn) begin
        ctl_reg[i] <= OCRB_CONTROL_RESET;
      end else begin
        ctl_reg[i] <= ctl_next[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // per-amplifier decode, from the next register values
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_AMPS; g++) begin : g_amp
      wire [7:0] ca     = ctl_next[2*g];
      wire [7:0] cb     = ctl_next[2*g+1];
      wire [1:0] inv    = ca[OCRB_INV_SEL_LSB +: 2];
      wire [1:0] ninv   = ca[OCRB_NONINV_SEL_LSB +: 2];
      wire [1:0] slew   = ca[OCRB_SLEW_LSB +: 2];
      wire [1:0] route  = ca[OCRB_ROUTE_LSB +: 2];
      wire [2:0] tap    = cb[OCRB_TAP_LSB +: 3];
      wire [2:0] func   = cb[OCRB_FUNC_LSB +: 3];
      wire       on     = slew != OCRB_SLEW_OFF;
      wire       gp     = func == OCRB_FUNC_GENERAL;
      // routing is ignored while the amplifier is off
      wire       pins   = on && (gp || route == OCRB_ROUTE_UPPER || route == OCRB_ROUTE_LOWER);
      wire       low    = on && (gp ? !route[0] : route == OCRB_ROUTE_LOWER);
      wire       high   = on && (gp ? route[0] : route[0]);
      wire       disc   = on && !gp && route == 2'h3;
      // ladder is isolated in general-purpose and plain unity-buffer functions
      wire       ladder = !gp && func != OCRB_FUNC_UNITY;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          inverting_input_sel[g]      <= 4'h1;
          noninverting_input_sel[g]   <= 4'h1;
          slew_power_sel[g]           <= 2'h0;
          amp_output_hiz[g]           <= 1'b1;
          amp_output_to_pins[g]       <= 1'b0;
          amp_output_to_adc_lower[g]  <= 1'b0;
          amp_output_to_adc_upper[g]  <= 1'b0;
          adc_upper_pin_disconnect[g] <= 1'b0;
          feedback_tap_sel[g]         <= 3'h0;
          amp_function_sel[g]         <= 8'h01;
          inverting_pin_expose[g]     <= 1'b0;
          ladder_reverse[g]           <= 1'b0;
          diff_gain_x3[g]             <= 6'h00;
        end else begin
          inverting_input_sel[g]      <= 4'h1 << inv;
          noninverting_input_sel[g]   <= 4'h1 << ninv;
          slew_power_sel[g]           <= slew;
          amp_output_hiz[g]           <= !on;
          amp_output_to_pins[g]       <= pins;
          amp_output_to_adc_lower[g]  <= low;
          amp_output_to_adc_upper[g]  <= high;
          adc_upper_pin_disconnect[g] <= disc;
          feedback_tap_sel[g]         <= tap;
          amp_function_sel[g]         <= 8'h01 << func;
          inverting_pin_expose[g]     <= cb[OCRB_EXPOSE_BIT] && ladder;
          ladder_reverse[g]           <= cb[OCRB_REVERSE_BIT] && func == OCRB_FUNC_COMPARE;
          diff_gain_x3[g]             <= gain_x3(tap);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb_main @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_clear_a: assert property ($rose(aresetn) |-> ctl_reg[0] == 8'h00 && ctl_reg[5] == 8'h00)
    else $error("control registers not clear after reset");
  inv_select_a: assert property (inverting_input_sel[0] == (4'h1 << ctl_reg[0][7:6]))
    else $error("inverting select does not follow register");
  noninv_select_a: assert property (1'b1 |=> noninverting_input_sel[1] == (4'h1 << ctl_reg[2][5:4]))
    else $error("non-inverting select does not follow register");
  slew_off_a: assert property (ctl_reg[0][3:2] == 2'h0 |-> amp_output_hiz[0] && !amp_output_to_pins[0]
                                && !amp_output_to_adc_lower[0] && !amp_output_to_adc_upper[0])
    else $error("amplifier off but output routed");
  route_general_a: assert property (ctl_reg[0][3:2] != 2'h0 && ctl_reg[1][4:2] == 3'h0 |->
                                     amp_output_to_pins[0] && amp_output_to_adc_upper[0] == ctl_reg[0][0])
    else $error("general-purpose routing wrong");
  route_internal_a: assert property (ctl_reg[2][3:2] != 2'h0 && ctl_reg[3][4:2] != 3'h0 && ctl_reg[2][1:0] == 2'h3
                                      |-> adc_upper_pin_disconnect[1] && !amp_output_to_pins[1])
    else $error("internal upper routing wrong");
  tap_function_a: assert property (1'b1 |=> feedback_tap_sel[2] == ctl_reg[5][7:5]
                                    && amp_function_sel[2] == (8'h01 << ctl_reg[5][4:2]))
    else $error("tap or function select does not follow register");
  expose_pin_a: assert property (ctl_reg[1][4:2] == 3'h0 |-> !inverting_pin_expose[0])
    else $error("inverting pin exposed without resistor network");
  ladder_swap_a: assert property (ladder_reverse[0] |-> ctl_reg[1][4:2] == 3'h3 && ctl_reg[1][0])
    else $error("ladder reversed outside comparator function");
  diff_gain_a: assert property (feedback_tap_sel[0] == 3'h7 |-> diff_gain_x3[0] == 6'h2D)
    else $error("top tap gain is not fifteen");
  write_visible_a: assert property (wr_commit && wr_slot[2:0] == 3'h1 |=>
                                     ctl_reg[1] == $past(wbyte_reg) && s_axi_bvalid)
    else $error("write not visible at next edge");
  read_stable_a: assert property (ar_take && !wr_commit |=> s_axi_rvalid
                                  && ctl_reg[0] == $past(ctl_reg[0]))
    else $error("read changed register state");

endmodule : ocrb_opamp_control_register_bank
`default_nettype wire

// ===== ocrb_opamp_control_register_bank_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ocrb_opamp_control_register_bank_bench;
  import ocrb_pkg::*;
  typedef struct packed {logic [1:0] amp; logic [7:0] a; logic [7:0] b; logic [3:0] route;} ocrb_row_type;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [11:0]       awaddr = 12'h000, araddr = 12'h000;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0]       wdata = 32'h0;
  logic [3:0]        wstrb = 4'h0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [2:0][3:0]   inv_sel, noninv_sel;
  logic [2:0][1:0]   slew;
  logic [2:0]        hiz, to_pins, to_lower, to_upper, upper_disc, expose, reverse;
  logic [2:0][2:0]   tap;
  logic [2:0][7:0]   func;
  logic [2:0][5:0]   gain;
  int                miscompares = 0;
  int                n_tests = 0;
  localparam logic [5:0] GAIN_X3 [8] = '{6'h00, 6'h01, 6'h03, 6'h05, 6'h09, 6'h0D, 6'h15, 6'h2D};
  // route columns: pins, lower, upper, upper pin disconnect
  localparam ocrb_row_type ROWS [14] = '{
    '{2'h0, 8'h00, 8'h00, 4'h0}, '{2'h0, 8'h54, 8'h00, 4'hC}, '{2'h1, 8'hA9, 8'h20, 4'hA},
    '{2'h2, 8'hFE, 8'h40, 4'hC}, '{2'h0, 8'h07, 8'h60, 4'hA}, '{2'h1, 8'h04, 8'h84, 4'h0},
    '{2'h2, 8'h05, 8'hA8, 4'hA}, '{2'h0, 8'h06, 8'hCF, 4'hC}, '{2'h1, 8'h0B, 8'hF0, 4'h3},
    '{2'h2, 8'h0F, 8'h17, 4'h3}, '{2'h0, 8'h0D, 8'h1A, 4'hA}, '{2'h1, 8'h0E, 8'h1D, 4'hC},
    '{2'h2, 8'h0C, 8'h0B, 4'h0}, '{2'h0, 8'hF3, 8'h0C, 4'h0}};

  always #10 aclk = ~aclk;

  ocrb_opamp_control_register_bank #(.ADDR_WIDTH(12), .NUM_AMPS(3)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .inverting_input_sel(inv_sel), .noninverting_input_sel(noninv_sel), .slew_power_sel(slew),
    .amp_output_hiz(hiz), .amp_output_to_pins(to_pins), .amp_output_to_adc_lower(to_lower),
    .amp_output_to_adc_upper(to_upper), .adc_upper_pin_disconnect(upper_disc),
    .feedback_tap_sel(tap), .amp_function_sel(func), .inverting_pin_expose(expose),
    .ladder_reverse(reverse), .diff_gain_x3(gain));

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timed_out();
    miscompares++;
    $display("[ERR] %0t bus handshake timed out", $time);
    print_verdict();
  endtask : timed_out

  function automatic logic [11:0] addr_of(input logic [1:0] amp, input logic second);
    return 12'h300 + 12'(amp) * 12'h008 + (second ? 12'h004 : 12'h000);
  endfunction : addr_of

  // called just after a rising edge; holds each channel until its own handshake
  task automatic axi_write(input logic [11:0] addr, input logic [7:0] data, input logic [3:0] strb,
                           input logic [1:0] exp_resp);
    int   n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= addr; awvalid <= 1'b1; wdata <= {24'h000000, data}; wstrb <= strb; wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (n > 50) timed_out();
      if (aw_done && w_done && bvalid) break;
      if (!aw_done && awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (!w_done && wready) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    check(32'(bresp), 32'(exp_resp));
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] addr, input logic [7:0] exp_data, input logic [1:0] exp_resp);
    int   n;
    logic ar_done;
    n = 0;
    ar_done = 1'b0;
    araddr <= addr; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (n > 50) timed_out();
      if (ar_done && rvalid) break;
      if (!ar_done && arready) begin ar_done = 1'b1; arvalid <= 1'b0; end
    end
    check(rdata, {24'h000000, exp_data});
    check(32'(rresp), 32'(exp_resp));
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  task automatic check_amp(input int k, input logic [7:0] a, input logic [7:0] b, input logic [3:0] route);
    check(32'(inv_sel[k]), 32'(4'h1 << a[7:6]));
    check(32'(noninv_sel[k]), 32'(4'h1 << a[5:4]));
    check(32'({slew[k], hiz[k]}), 32'({a[3:2], a[3:2] == 2'h0}));
    check(32'({to_pins[k], to_lower[k], to_upper[k], upper_disc[k]}), 32'(route));
    check(32'(tap[k]), 32'(b[7:5]));
    check(32'(func[k]), 32'(8'h01 << b[4:2]));
    check(32'(expose[k]), 32'(b[1] && b[4:2] != 3'h0 && b[4:2] != 3'h2));
    check(32'(reverse[k]), 32'(b[0] && b[4:2] == 3'h3));
    check(32'(gain[k]), 32'(GAIN_X3[b[7:5]]));
  endtask : check_amp

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] sha [3];
    logic [7:0] shb [3];
    logic [3:0] shr [3];
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ROWS[i]) begin
      axi_write(addr_of(ROWS[i].amp, 1'b0), ROWS[i].a, 4'hF, OCRB_RESP_OKAY);
      axi_write(addr_of(ROWS[i].amp, 1'b1), ROWS[i].b, 4'hF, OCRB_RESP_OKAY);
      check_amp(ROWS[i].amp, ROWS[i].a, ROWS[i].b, ROWS[i].route);
      axi_read(addr_of(ROWS[i].amp, 1'b0), ROWS[i].a, OCRB_RESP_OKAY);
      axi_read(addr_of(ROWS[i].amp, 1'b1), ROWS[i].b, OCRB_RESP_OKAY);
      sha[ROWS[i].amp] = ROWS[i].a;
      shb[ROWS[i].amp] = ROWS[i].b;
      shr[ROWS[i].amp] = ROWS[i].route;
    end
    // later writes to one amplifier leave the others alone
    for (int k = 0; k < 3; k++) check_amp(k, sha[k], shb[k], shr[k]);
    // masked byte lane and unmapped places
    axi_write(12'h300, 8'h55, 4'hE, OCRB_RESP_OKAY);
    axi_read(12'h300, sha[0], OCRB_RESP_OKAY);
    axi_write(12'h318, 8'hFF, 4'hF, OCRB_RESP_SLVERR);
    axi_write(12'h2FC, 8'hFF, 4'hF, OCRB_RESP_SLVERR);
    axi_read(12'h318, 8'h00, OCRB_RESP_SLVERR);
    axi_read(12'h2FC, 8'h00, OCRB_RESP_SLVERR);
    axi_read(12'h314, shb[2], OCRB_RESP_OKAY);
    // differential stage: software gives amplifiers zero and two the same top tap
    axi_write(addr_of(2'h0, 1'b1), 8'hE4, 4'hF, OCRB_RESP_OKAY);
    axi_write(addr_of(2'h2, 1'b1), 8'hF8, 4'hF, OCRB_RESP_OKAY);
    check_amp(0, sha[0], 8'hE4, 4'h0);
    check_amp(2, sha[2], 8'hF8, 4'h0);
    check(32'(gain[0]), 32'(GAIN_X3[3'h7]));
    check(32'(gain[2]), 32'(GAIN_X3[3'h7]));
    // reset in mid-run clears every register and returns each decoded output to its reset value
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    for (int k = 0; k < 3; k++) check_amp(k, 8'h00, 8'h00, 4'h0);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int k = 0; k < 6; k++) axi_read(12'h300 + 12'(k) * 12'h004, OCRB_CONTROL_RESET, OCRB_RESP_OKAY);
    print_verdict();
  end
endmodule : ocrb_opamp_control_register_bank_bench
`default_nettype wire

// ===== ocrb_pkg.sv
`default_nettype none
package ocrb_pkg;
  // ---------------------------------------------------------------
  // register map: printed offsets are indices, byte address = 4 * index
  // ---------------------------------------------------------------
  localparam logic [9:0] OCRB_AMP0_CONTROL_A_IDX = 10'h0C0;
  localparam logic [9:0] OCRB_AMP0_CONTROL_B_IDX = 10'h0C1;
  localparam logic [9:0] OCRB_AMP1_CONTROL_A_IDX = 10'h0C2;
  localparam logic [9:0] OCRB_AMP1_CONTROL_B_IDX = 10'h0C3;
  localparam logic [9:0] OCRB_AMP2_CONTROL_A_IDX = 10'h0C4;
  localparam logic [9:0] OCRB_AMP2_CONTROL_B_IDX = 10'h0C5;
  localparam int         OCRB_NUM_REGS           = 6;
  localparam logic [7:0] OCRB_CONTROL_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // field positions, control a
  // ---------------------------------------------------------------
  localparam int OCRB_INV_SEL_LSB    = 6;
  localparam int OCRB_NONINV_SEL_LSB = 4;
  localparam int OCRB_SLEW_LSB       = 2;
  localparam int OCRB_ROUTE_LSB      = 0;

  // ---------------------------------------------------------------
  // field positions, control b
  // ---------------------------------------------------------------
  localparam int OCRB_TAP_LSB        = 5;
  localparam int OCRB_FUNC_LSB       = 2;
  localparam int OCRB_EXPOSE_BIT     = 1;
  localparam int OCRB_REVERSE_BIT    = 0;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] OCRB_SLEW_OFF      = 2'h0;
  localparam logic [1:0] OCRB_ROUTE_INT     = 2'h0;
  localparam logic [1:0] OCRB_ROUTE_UPPER   = 2'h1;
  localparam logic [1:0] OCRB_ROUTE_LOWER   = 2'h2;
  localparam logic [2:0] OCRB_FUNC_GENERAL  = 3'h0;
  localparam logic [2:0] OCRB_FUNC_UNITY    = 3'h2;
  localparam logic [2:0] OCRB_FUNC_COMPARE  = 3'h3;
  localparam logic [1:0] OCRB_RESP_OKAY     = 2'h0;
  localparam logic [1:0] OCRB_RESP_SLVERR   = 2'h2;
endpackage : ocrb_pkg
`default_nettype wire
